// ===== include/sfct_pkg.sv
// Constants and types for the sinc filter conversion timing block
// Notes on behaviour
// - Setting zero_latency_select makes each single-channel conversion span one full settling period.
// - Zero latency sinc3 on one channel gives a result every 3 x 32 x rate_divider_word master clocks.
// - A channel switch adds a dead time of 61 master clocks when rate_divider_word is 1 outside fast settling, else 95.
// - After any channel change the first result waits the full settling time, whatever zero latency holds.
// - Zero latency single channel gives settled results, with one partly settled result on an unaligned step.
// - With several channels enabled the block cycles through them, first full settling, later dead time 30.
// - extra_60hz_notch at a 50 Hz sinc notch adds a 60 Hz notch; rate is 50 SPS or 16.67 SPS sinc3 zero latency.
// - Fast settling inserts a sinc1 averager after the sinc4 stage.
// - The averaging factor is 16 in full and mid power and 8 in low power.
// - Sinc4 fast settling on one channel gives a result every (4 + avg - 1) x 32 x rate_divider_word clocks.
// - Sinc4 fast settling first result after a channel change takes that period plus 95 master clocks.
// - rate_divider_word is 11 bits, valid from 1 to 2047; a written zero is held at 1.
// - The filter clock is 614.4 kHz in full power, 153.6 kHz in mid and 76.8 kHz in low power.
// - Sinc4 fast settling keeps converting through a step, one partly settled result if unaligned.
// - Without zero latency sinc3 single-channel results come every 32 x rate_divider_word clocks.
// - A channel change resets modulator and decimation filter before the new settling period.
package sfct_pkg;
  localparam int unsigned SFCT_SYS_CLK_HZ = 25000000;
  localparam int unsigned SFCT_MCLK_FULL_HZ = 614400;
  localparam int unsigned SFCT_MCLK_MID_HZ = 153600;
  localparam int unsigned SFCT_MCLK_LOW_HZ = 76800;
  localparam int unsigned SFCT_OSR = 32;
  localparam int unsigned SFCT_SINC3_ORDER = 3;
  localparam int unsigned SFCT_SINC4_ORDER = 4;
  localparam int unsigned SFCT_DEAD_FS1 = 61;
  localparam int unsigned SFCT_DEAD_FSN = 95;
  localparam int unsigned SFCT_DEAD_SEQ = 30;
  localparam int unsigned SFCT_AVG_FULL_MID = 16;
  localparam int unsigned SFCT_AVG_LOW = 8;
  localparam int unsigned SFCT_EXTRA_60HZ_NOTCH_DIV = 5;
  localparam int unsigned SFCT_EXTRA_60HZ_NOTCH_MUL = 6;
  localparam int unsigned SFCT_FS_W = 11;
  localparam int unsigned SFCT_FS_MIN = 1;
  localparam int unsigned SFCT_FS_MAX = 2047;
  localparam int unsigned SFCT_FS_50HZ_FULL = 384;
  localparam int unsigned SFCT_FS_50HZ_MID = 96;
  localparam int unsigned SFCT_FS_50HZ_LOW = 48;
  localparam int unsigned SFCT_DATA_W = 24;
  localparam int unsigned SFCT_CH_W = 4;
  localparam int unsigned SFCT_CNT_W = 21;
  localparam int unsigned SFCT_ACC_W = 40;
  // Register byte addresses (word aligned)
  localparam logic [3:0] SFCT_ADDR_FILTER = 4'h0;
  localparam logic [3:0] SFCT_ADDR_CHEN = 4'h4;
  localparam logic [3:0] SFCT_ADDR_STATUS = 4'h8;
  localparam logic [3:0] SFCT_ADDR_DATA = 4'hC;
  // Filter register fields
  localparam int unsigned SFCT_F_FS_LSB = 0;
  localparam int unsigned SFCT_F_ZL_BIT = 16;
  localparam int unsigned SFCT_F_EXTRA_60HZ_NOTCH_BIT = 17;
  localparam int unsigned SFCT_F_TYPE_LSB = 20;
  localparam int unsigned SFCT_F_PWR_LSB = 24;
  localparam logic [31:0] SFCT_FILTER_RST = 32'h0000_0180;
  localparam logic [15:0] SFCT_CHEN_RST = 16'h0001;
  localparam logic [31:0] SFCT_UNMAPPED_RD = 32'h0000_0000;
  typedef enum logic [1:0] {
    SFCT_TYPE_SINC4 = 2'h0,
    SFCT_TYPE_SINC3 = 2'h1,
    SFCT_TYPE_FAST4 = 2'h2
  } sfct_ftype_e;
  typedef enum logic [1:0] {
    SFCT_PWR_LOW = 2'h0,
    SFCT_PWR_MID = 2'h1,
    SFCT_PWR_FULL = 2'h2
  } sfct_pwr_e;
  typedef enum logic [2:0] {
    SFCT_ST_IDLE = 3'b001,
    SFCT_ST_DEAD = 3'b010,
    SFCT_ST_CONV = 3'b100
  } sfct_state_e;
endpackage

// ===== src/sfct_top.sv
// Conversion timing and mode control of the decimation filter with Avalon-MM registers
//
// Decided for this implementation: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
module sfct_top #(
  parameter int unsigned NUM_CH = 16
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Avalon-MM slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Modulator bitstream
  input wire logic mod_bit_i,
  // Modulator and filter control
  output logic mclk_tick_o,
  output logic filter_reset_o,
  output logic [sfct_pkg::SFCT_CH_W-1:0] active_ch_o,
  // Result stream
  output logic [sfct_pkg::SFCT_DATA_W-1:0] result_o,
  output logic [sfct_pkg::SFCT_CH_W-1:0] result_ch_o,
  output logic data_ready_o
);
  import sfct_pkg::*;

  // Channel enables are one 16-bit register, so more channels cannot be served
  if (NUM_CH < 1 || NUM_CH > 16) begin : g_bad_num_ch
    $error("NUM_CH must be 1 to 16");
  end

  // Master clock dividers from the 25 MHz system clock
  localparam int unsigned DIV_FULL = SFCT_SYS_CLK_HZ / SFCT_MCLK_FULL_HZ;
  localparam int unsigned DIV_MID = SFCT_SYS_CLK_HZ / SFCT_MCLK_MID_HZ;
  localparam int unsigned DIV_LOW = SFCT_SYS_CLK_HZ / SFCT_MCLK_LOW_HZ;

  typedef struct packed {
    logic [31:0] filter;
    logic [15:0] ch_en;
    logic [9:0] div_cnt;
    logic tick;
    sfct_state_e state;
    logic [SFCT_CNT_W-1:0] cnt;
    logic [SFCT_CH_W-1:0] ch;
    logic seq_run;
    logic [SFCT_ACC_W-1:0] acc;
    logic [SFCT_DATA_W-1:0] result;
    logic [SFCT_CH_W-1:0] result_ch;
    logic rdy_pulse;
    logic rdy_flag;
    logic filt_rst;
    logic [31:0] rdata;
    logic rvalid;
  } sfct_state_s;

  sfct_state_s state_reg;
  sfct_state_s state_next;

  logic [SFCT_FS_W-1:0] fs;
  logic zl;
  logic extra_60hz_notch;
  sfct_ftype_e ftype;
  sfct_pwr_e pwr;
  logic [9:0] div_max;
  logic [4:0] avg;
  logic [4:0] order;
  logic [SFCT_CNT_W-1:0] period;
  logic [SFCT_CNT_W-1:0] first_per;
  logic [SFCT_CNT_W-1:0] dead;
  logic [SFCT_CH_W-1:0] nxt_ch;
  logic multi;
  logic bus_access;
  logic [31:0] filt_wr;
  logic [15:0] chen_wr;

  always_comb begin
    fs = state_reg.filter[SFCT_F_FS_LSB +: SFCT_FS_W];
    zl = state_reg.filter[SFCT_F_ZL_BIT];
    extra_60hz_notch = state_reg.filter[SFCT_F_EXTRA_60HZ_NOTCH_BIT];
    ftype = sfct_ftype_e'(state_reg.filter[SFCT_F_TYPE_LSB +: 2]);
    pwr = sfct_pwr_e'(state_reg.filter[SFCT_F_PWR_LSB +: 2]);
    // Filter clock per power mode
    case (pwr)
      SFCT_PWR_FULL: div_max = 10'(DIV_FULL - 1);
      SFCT_PWR_MID: div_max = 10'(DIV_MID - 1);
      default: div_max = 10'(DIV_LOW - 1);
    endcase
    // Averaging factor
    avg = (pwr == SFCT_PWR_LOW) ? 5'(SFCT_AVG_LOW) : 5'(SFCT_AVG_FULL_MID);
    // Dead time depends on rate divider
    // Fast settling always uses the long dead time
    if (fs == 11'(SFCT_FS_MIN) && ftype != SFCT_TYPE_FAST4) begin
      dead = SFCT_CNT_W'(SFCT_DEAD_FS1);
    end else begin
      dead = SFCT_CNT_W'(SFCT_DEAD_FSN);
    end
    // Filter order in words of 32 x fs: sinc1 appended in fast settling
    case (ftype)
      SFCT_TYPE_FAST4: order = 5'(SFCT_SINC4_ORDER) + avg - 5'h01;
      SFCT_TYPE_SINC3: order = 5'(SFCT_SINC3_ORDER);
      default: order = 5'(SFCT_SINC4_ORDER);
    endcase
    first_per = SFCT_CNT_W'(order) * SFCT_CNT_W'(SFCT_OSR) * SFCT_CNT_W'(fs);
    // Settled period per result: full order when zero latency or fast settling
    if (zl || ftype == SFCT_TYPE_FAST4) begin
      period = first_per;
    end else begin
      period = SFCT_CNT_W'(SFCT_OSR) * SFCT_CNT_W'(fs);
    end
    // 60 Hz notch stretches the first conversion by 5 master clocks at the 50 Hz setting
    if (extra_60hz_notch && ftype != SFCT_TYPE_FAST4 &&
        ((pwr == SFCT_PWR_FULL && fs == 11'(SFCT_FS_50HZ_FULL)) ||
         (pwr == SFCT_PWR_MID && fs == 11'(SFCT_FS_50HZ_MID)) ||
         (pwr == SFCT_PWR_LOW && fs == 11'(SFCT_FS_50HZ_LOW)))) begin
      first_per = first_per + SFCT_CNT_W'(SFCT_EXTRA_60HZ_NOTCH_DIV);
    end
    multi = ($countones(state_reg.ch_en) > 1);
    nxt_ch = state_reg.ch;
    for (int i = NUM_CH - 1; i >= 1; i--) begin
      if (state_reg.ch_en[(int'(state_reg.ch) + i) % NUM_CH]) begin
        nxt_ch = SFCT_CH_W'((int'(state_reg.ch) + i) % NUM_CH);
      end
    end
    bus_access = (avs_read_i || avs_write_i) && !state_reg.rvalid;
    filt_wr = state_reg.filter;
    for (int b = 0; b < 4; b++) begin
      if (avs_byteenable_i[b]) begin
        filt_wr[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
      end
    end
    chen_wr = state_reg.ch_en;
    for (int b = 0; b < 2; b++) begin
      if (avs_byteenable_i[b]) begin
        chen_wr[b*8 +: 8] = avs_writedata_i[b*8 +: 8];
      end
    end
    if (NUM_CH < 16) begin
      chen_wr = chen_wr & 16'((32'h1 << NUM_CH) - 1);
    end

    state_next = state_reg;
    state_next.rdy_pulse = 1'b0;
    state_next.filt_rst = 1'b0;
    state_next.rvalid = 1'b0;
    // Master clock tick generator
    if (state_reg.div_cnt >= div_max) begin
      state_next.div_cnt = 10'h000;
      state_next.tick = 1'b1;
    end else begin
      state_next.div_cnt = state_reg.div_cnt + 10'h001;
      state_next.tick = 1'b0;
    end
    // Modulator bits summed into a boxcar per conversion
    if (state_reg.tick && state_reg.state == SFCT_ST_CONV) begin
      state_next.acc = state_reg.acc + SFCT_ACC_W'(mod_bit_i);
    end

    case (state_reg.state)
      SFCT_ST_IDLE: begin
        if (state_reg.ch_en != 16'h0000) begin
          state_next.state = SFCT_ST_DEAD;
          state_next.cnt = dead;
          state_next.seq_run = 1'b0;
          state_next.filt_rst = 1'b1;
          state_next.acc = '0;
          state_next.ch = state_reg.ch_en[state_reg.ch] ? state_reg.ch : nxt_ch;
        end
      end
      SFCT_ST_DEAD: begin
        if (state_reg.tick) begin
          if (state_reg.cnt <= SFCT_CNT_W'(1)) begin
            state_next.state = SFCT_ST_CONV;
            // Full settling after every channel change
            state_next.cnt = first_per;
          end else begin
            state_next.cnt = state_reg.cnt - SFCT_CNT_W'(1);
          end
        end
      end
      SFCT_ST_CONV: begin
        if (state_reg.tick) begin
          if (state_reg.cnt <= SFCT_CNT_W'(1)) begin
            // The last modulator sample of the conversion belongs to this result
            state_next.result = SFCT_DATA_W'(state_reg.acc + SFCT_ACC_W'(mod_bit_i));
            state_next.result_ch = state_reg.ch;
            state_next.rdy_pulse = 1'b1;
            state_next.rdy_flag = 1'b1;
            if (multi) begin
              // Sequencer moves on with reduced dead time
              state_next.ch = nxt_ch;
              state_next.state = SFCT_ST_DEAD;
              state_next.cnt = SFCT_CNT_W'(SFCT_DEAD_SEQ);
              state_next.seq_run = 1'b1;
              state_next.filt_rst = 1'b1;
              state_next.acc = '0;
            end else begin
              // Continuous conversion without reset so steps flow through
              state_next.cnt = period;
              state_next.acc = '0;
            end
          end else begin
            state_next.cnt = state_reg.cnt - SFCT_CNT_W'(1);
          end
        end
      end
      default: begin
        state_next.state = SFCT_ST_IDLE;
      end
    endcase

    // Register access; reconfiguration restarts the settling sequence
    if (bus_access && avs_write_i) begin
      case (avs_address_i)
        SFCT_ADDR_FILTER: begin
          state_next.filter = filt_wr;
          // Out-of-range divider of zero is held at the minimum
          if (filt_wr[SFCT_F_FS_LSB +: SFCT_FS_W] == '0) begin
            state_next.filter[SFCT_F_FS_LSB +: SFCT_FS_W] = 11'(SFCT_FS_MIN);
          end
          state_next.state = SFCT_ST_IDLE;
        end
        SFCT_ADDR_CHEN: begin
          state_next.ch_en = chen_wr;
          state_next.state = SFCT_ST_IDLE;
        end
        default: begin
        end
      endcase
    end
    if (bus_access && avs_read_i) begin
      state_next.rvalid = 1'b1;
      case (avs_address_i)
        SFCT_ADDR_FILTER: state_next.rdata = state_reg.filter;
        SFCT_ADDR_CHEN: state_next.rdata = {16'h0000, state_reg.ch_en};
        SFCT_ADDR_STATUS: state_next.rdata = {21'h00_0000, state_reg.seq_run, 3'(state_reg.state),
                                              state_reg.rdy_flag, 2'h0, state_reg.ch};
        SFCT_ADDR_DATA: begin
          state_next.rdata = {8'h00, state_reg.result};
          state_next.rdy_flag = 1'b0;
        end
        default: state_next.rdata = SFCT_UNMAPPED_RD;
      endcase
    end
    // New result wins over the clear by a data read
    if (state_reg.state == SFCT_ST_CONV && state_reg.tick && state_reg.cnt <= SFCT_CNT_W'(1)) begin
      state_next.rdy_flag = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= '{filter: SFCT_FILTER_RST, ch_en: SFCT_CHEN_RST, state: SFCT_ST_IDLE, default: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign avs_waitrequest_o = (avs_read_i && !state_reg.rvalid);
  assign avs_readdata_o = state_reg.rdata;
  assign mclk_tick_o = state_reg.tick;
  assign filter_reset_o = state_reg.filt_rst;
  assign active_ch_o = state_reg.ch;
  assign result_o = state_reg.result;
  assign result_ch_o = state_reg.result_ch;
  assign data_ready_o = state_reg.rdy_pulse;
endmodule

// ===== tb/sfct_chk.sv
// Port-level assertions for the conversion timing block
`timescale 1ns/10ps
module sfct_chk (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Bus handshake
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  // Conversion outputs
  input wire logic mclk_tick_o,
  input wire logic filter_reset_o,
  input wire logic [sfct_pkg::SFCT_CH_W-1:0] active_ch_o,
  input wire logic [sfct_pkg::SFCT_DATA_W-1:0] result_o,
  input wire logic data_ready_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  // Master ticks since the last modulator and filter reset
  int unsigned tk;
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      tk <= 0;
    end else if (filter_reset_o) begin
      tk <= 0;
    end else if (mclk_tick_o && tk < 1000) begin
      tk <= tk + 1;
    end
  end
  a_ready_one_pulse: assert property (data_ready_o |=> !data_ready_o)
    else $error("data ready longer than one cycle");
  a_reset_one_pulse: assert property (filter_reset_o |=> !filter_reset_o)
    else $error("filter reset longer than one cycle");
  a_tick_spacing: assert property (mclk_tick_o |=> !mclk_tick_o [*8])
    else $error("master ticks too close");
  a_write_no_wait: assert property (avs_write_i && !avs_read_i |-> !avs_waitrequest_o)
    else $error("write was made to wait");
  a_read_one_wait: assert property (avs_read_i && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("read waited more than one cycle");
  a_result_with_ready: assert property ($changed(result_o) |-> data_ready_o)
    else $error("result changed without data ready");
  a_dead_time_min: assert property (data_ready_o |-> tk > 60)
    else $error("result came before the dead time");
  a_channel_reset: assert property ($changed(active_ch_o) |-> filter_reset_o || $past(filter_reset_o))
    else $error("channel changed without filter reset");
  c_result: cover property (data_ready_o);
  c_read_done: cover property (avs_read_i && !avs_waitrequest_o);
  c_channel_change: cover property ($changed(active_ch_o));
endmodule

// ===== tb/sfct_mod_src.sv
// Modulator bitstream source standing in for the front end
`timescale 1ns/10ps
module sfct_mod_src (
  // Clock and tick
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic mclk_tick_i,
  // Bitstream
  output logic mod_bit_o
);
  // A fresh random bit each master clock, so a stuck sampler cannot hide
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      mod_bit_o <= 1'b0;
    end else if (mclk_tick_i) begin
      mod_bit_o <= 1'($urandom);
    end
  end
endmodule

// ===== tb/tb_sfct_top.sv
// Self-checking bench for the conversion timing block
`timescale 1ns/10ps
module tb_sfct_top;
  import sfct_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat;
  logic wt, tick, frst, rdy, mbit;
  logic [SFCT_CH_W-1:0] ach, rch;
  logic [SFCT_DATA_W-1:0] res;
  logic [31:0] v;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int first, per, c, fs, dd, s1, s2;
  logic [SFCT_DATA_W-1:0] r1;
  int so[3] = '{SFCT_SINC3_ORDER, SFCT_SINC3_ORDER, SFCT_SINC4_ORDER + SFCT_AVG_FULL_MID - 1};
  int hz[3] = '{SFCT_MCLK_LOW_HZ, SFCT_MCLK_MID_HZ, SFCT_MCLK_FULL_HZ};
  int ty[3] = '{1, 1, 2};
  int zl[3] = '{0, 1, 0};
  int od[3] = '{1, 3, 19};
  sfct_top uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .mod_bit_i(mbit), .mclk_tick_o(tick), .filter_reset_o(frst),
    .active_ch_o(ach), .result_o(res), .result_ch_o(rch), .data_ready_o(rdy));
  sfct_mod_src src (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .mclk_tick_i(tick), .mod_bit_o(mbit));
  initial begin
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Ceiling a little above the roughly 90000 cycles that the scenarios need
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 99000) begin
      errors++;
      finish_test();
    end
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One Avalon transfer; the request stands until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk_sys_i);
    end while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  // Ticks from filter reset to the first result, then to the next result; ticks past the
  // dead count of each stretch are conversion ticks, and their modulator ones are summed
  task automatic measure(input int d1, input int d2, output int f, output int p, output int t1,
    output int t2, output logic [SFCT_DATA_W-1:0] q1);
    int n;
    do @(negedge clk_sys_i); while (frst !== 1'b1);
    n = 0;
    t1 = 0;
    while (rdy !== 1'b1) begin
      if (tick === 1'b1) begin
        n++;
        if (n > d1) begin
          t1 += int'(mbit);
        end
      end
      @(negedge clk_sys_i);
    end
    f = n;
    q1 = res;
    n = 0;
    t2 = 0;
    do begin
      @(negedge clk_sys_i);
      if (tick === 1'b1) begin
        n++;
        if (n > d2) begin
          t2 += int'(mbit);
        end
      end
    end while (rdy !== 1'b1);
    p = n;
  endtask
  task automatic tgap(output int n);
    n = 0;
    do @(negedge clk_sys_i); while (tick !== 1'b1);
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (tick !== 1'b1);
  endtask
  initial begin
    void'($urandom(32'hcd22));
    repeat (12) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    bus(1'b0, SFCT_ADDR_FILTER, 32'h0000_0000, v);
    check("filter_reset", v, SFCT_FILTER_RST);
    bus(1'b0, SFCT_ADDR_CHEN, 32'h0000_0000, v);
    check("chen_reset", v, 32'(SFCT_CHEN_RST));
    bus(1'b0, 4'h1, 32'h0000_0000, v);
    check("unmapped", v, SFCT_UNMAPPED_RD);
    for (int p = 0; p < 3; p++) begin
      bus(1'b1, SFCT_ADDR_FILTER, (32'(p) << 24) | 32'h0000_0001, v);
      tgap(c);
      check("tick_gap", 32'(c), 32'(SFCT_SYS_CLK_HZ / hz[p]));
    end
    bus(1'b1, SFCT_ADDR_FILTER, 32'h0200_0000, v);
    bus(1'b0, SFCT_ADDR_FILTER, 32'h0000_0000, v);
    check("fs_zero", v, 32'h0200_0001);
    for (int m = 0; m < 3; m++) begin
      fs = (m == 0) ? 1 + $urandom_range(1) : 1;
      bus(1'b1, SFCT_ADDR_FILTER, 32'(fs | zl[m] << 16 | ty[m] << 20 | 2 << 24), v);
      // Fast settling keeps the long dead time even at the smallest divider
      dd = (fs == 1 && m != 2) ? SFCT_DEAD_FS1 : SFCT_DEAD_FSN;
      measure(dd, 0, first, per, s1, s2, r1);
      check("first", 32'(first), 32'(dd + so[m] * 32 * fs));
      check("period", 32'(per), 32'(od[m] * 32 * fs));
      check("result_first", 32'(r1), 32'(s1));
      check("result_next", 32'(res), 32'(s2));
    end
    bus(1'b1, SFCT_ADDR_CHEN, 32'h0000_0005, v);
    bus(1'b1, SFCT_ADDR_FILTER, 32'h0210_0001, v);
    measure(SFCT_DEAD_FS1, SFCT_DEAD_SEQ, first, per, s1, s2, r1);
    check("seq_first", 32'(first), 32'(SFCT_DEAD_FS1 + SFCT_SINC3_ORDER * SFCT_OSR));
    check("seq_next", 32'(per), 32'(SFCT_DEAD_SEQ + SFCT_SINC3_ORDER * SFCT_OSR));
    check("seq_result_first", 32'(r1), 32'(s1));
    check("seq_result", 32'(res), 32'(s2));
    check("seq_ch", 32'(rch), 32'h0000_0002);
    check("active_ch", 32'(ach), 32'h0000_0000);
    bus(1'b0, SFCT_ADDR_STATUS, 32'h0000_0000, v);
    check("rdy_set", 32'(v[6]), 32'h0000_0001);
    bus(1'b0, SFCT_ADDR_DATA, 32'h0000_0000, v);
    check("data_read", v, 32'(s2));
    bus(1'b0, SFCT_ADDR_STATUS, 32'h0000_0000, v);
    check("rdy_clear", 32'(v[6]), 32'h0000_0000);
    finish_test();
  end
endmodule
bind sfct_top sfct_chk chk (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .mclk_tick_o(mclk_tick_o),
  .filter_reset_o(filter_reset_o), .active_ch_o(active_ch_o), .result_o(result_o),
  .data_ready_o(data_ready_o));
